/* design/spk_pkg.sv */
// Package: offsets, decode codes, field positions and reset values
`default_nettype none
package spk_pkg;
   localparam int STRANDS = 64;
   localparam logic [39:0] OFF_IRQ_IDENT = 40'h00_0000_0000;
   localparam logic [39:0] OFF_STRAND_IDENT = 40'h00_0000_0010;
   localparam logic [39:0] OFF_RUN_RW = 40'h00_0000_0050;
   localparam logic [39:0] OFF_RUN_STATUS = 40'h00_0000_0058;
   localparam logic [39:0] OFF_RUN_SET = 40'h00_0000_0060;
   localparam logic [39:0] OFF_RUN_CLEAR = 40'h00_0000_0068;
   localparam logic [39:0] OFF_SERIAL = 40'h80_0000_1000;
   localparam logic [39:0] OFF_FUSE = 40'h80_0000_1008;
   localparam logic [39:0] OFF_AVAIL = 40'h80_0000_1010;
   localparam logic [63:0] RST_FUSE = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] RST_AVAIL = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] RST_RUN = 64'h0000_0000_0000_0001;
   localparam logic [5:0] STRANDS_PER_CORE_M1 = 6'h07;
   localparam logic [5:0] VPROC_M1 = 6'h3F;
   localparam int STRAND_HI_LSB = 32;
   localparam int VPROC_HI_LSB = 16;
   localparam logic [7:0] CODE_OWN = 8'h80;
   localparam logic [7:0] CODE_CLK = 8'h83;
   localparam logic [7:0] CODE_MEM = 8'h84;
   localparam logic [7:0] CODE_TEST = 8'h85;
   localparam logic [7:0] CODE_DEBUG = 8'h86;
   localparam logic [7:0] CODE_DMA = 8'h88;
   localparam logic [7:0] CODE_RESET = 8'h89;
   localparam logic [7:0] CODE_SHARED = 8'h90;
   localparam logic [7:0] CODE_PCIE_LO = 8'hC0;
   localparam logic [7:0] CODE_PCIE_HI = 8'hCF;
   localparam logic [7:0] CODE_BOOT = 8'hFF;
   typedef enum logic [3:0] {
      SPK_TGT_NONE, SPK_TGT_RSVD, SPK_TGT_OWN, SPK_TGT_CLK, SPK_TGT_MEM,
      SPK_TGT_TEST, SPK_TGT_DEBUG, SPK_TGT_DMA, SPK_TGT_RESET,
      SPK_TGT_SHARED, SPK_TGT_PCIE, SPK_TGT_BOOT
   } spk_tgt_e;
endpackage : spk_pkg
`default_nettype wire

/* design/spk_addr_decode.sv */
// Registered upper-byte decode of an I/O physical address
`default_nettype none
module spk_addr_decode (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_valid,
   input wire logic [39:0] i_addr,
   output logic o_valid,
   output spk_pkg::spk_tgt_e o_target,
   output logic [1:0] o_mem_sel
);
   function automatic spk_pkg::spk_tgt_e spk_route(input logic [7:0] code);
      spk_pkg::spk_tgt_e t;
      t = spk_pkg::SPK_TGT_RSVD;
      if (!code[7]) begin
         t = spk_pkg::SPK_TGT_NONE;
      end else if (code[7:5] == 3'b101) begin
         t = spk_pkg::SPK_TGT_NONE;
      end else if (code >= spk_pkg::CODE_PCIE_LO && code <= spk_pkg::CODE_PCIE_HI) begin
         t = spk_pkg::SPK_TGT_PCIE;
      end else begin
         case (code)
            spk_pkg::CODE_OWN: t = spk_pkg::SPK_TGT_OWN;
            spk_pkg::CODE_CLK: t = spk_pkg::SPK_TGT_CLK;
            spk_pkg::CODE_MEM: t = spk_pkg::SPK_TGT_MEM;
            spk_pkg::CODE_TEST: t = spk_pkg::SPK_TGT_TEST;
            spk_pkg::CODE_DEBUG: t = spk_pkg::SPK_TGT_DEBUG;
            spk_pkg::CODE_DMA: t = spk_pkg::SPK_TGT_DMA;
            spk_pkg::CODE_RESET: t = spk_pkg::SPK_TGT_RESET;
            spk_pkg::CODE_SHARED: t = spk_pkg::SPK_TGT_SHARED;
            spk_pkg::CODE_BOOT: t = spk_pkg::SPK_TGT_BOOT;
            default: t = spk_pkg::SPK_TGT_RSVD;
         endcase
      end
      return t;
   endfunction : spk_route

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_target <= spk_pkg::SPK_TGT_NONE;
         o_mem_sel <= 2'b00;
      end else begin
         o_valid <= i_valid;
         o_target <= spk_route(i_addr[39:32]);
         o_mem_sel <= i_addr[13:12];
      end
   end
endmodule : spk_addr_decode
`default_nettype wire

/* design/spk_park_vec.sv */
// Strand-run control vector with set, clear and last-strand protection
`default_nettype none
module spk_park_vec #(
   parameter int STRANDS = 64
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_set_we,
   input wire logic i_clr_we,
   input wire logic [STRANDS-1:0] i_data,
   input wire logic [5:0] i_requester,
   output logic [STRANDS-1:0] o_run
);
   logic [STRANDS-1:0] run_d;
   initial begin
      if (STRANDS != 64) $error("spk_park_vec serves 64 strands only");
   end
   always_comb begin
      run_d = o_run;
      if (i_set_we) begin
         run_d = o_run | i_data;
      end else if (i_clr_we) begin
         run_d = o_run & ~i_data;
         if (run_d == '0) begin
            run_d[i_requester] = 1'b1;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_run <= spk_pkg::RST_RUN;
      end else begin
         o_run <= run_d;
      end
   end
endmodule : spk_park_vec
`default_nettype wire

/* design/spk_ncu_regs.sv */
// Shared strand-park registers, identity registers, management registers and I/O decode
`default_nettype none
//Contract
// - Write to set port sets run bits where data is one.
// - Write to clear port clears run bits where data is one.
// - Update parking all strands keeps the requesting strand running.
// - Self-parked strand executes nothing after the parking instruction.
// - Interrupt identity reads zero in 15:6, own identifier in 5:0.
// - Strand identity reads 7 in 37:32 and 3F in 21:16.
// - Identifier is core number in 5:3, strand in 2:0.
// - Forty-bit addresses; bit 39 selects memory or I/O.
// - Decode target from the eight top address bits.
// - Codes 00-7F, A0-BF unhandled; unlisted codes reserved.
// - Code 90 selects shared alternate-space registers.
// - Code 84 selects memory controller by bits 13:12.
// - Codes 80,83,85,86,88,89,FF route to their units.
// - Serial number is read-only with fixed documented fields.
// - Fuse status is read-only fuse value, all ones by default.
// - Strand availability mirrors fuses, same value per core.
// - Codes C0 through CF reserved for PCIe mapping.
// - Run control holds one bit per strand, one means run.
// - Running status shows one for running strands.
module spk_ncu_regs #(
   parameter int STRANDS = 64
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [39:0] i_addr,
   input wire logic [63:0] i_wdata,
   input wire logic [5:0] i_requester,
   input wire logic [63:0] i_serial,
   input wire logic [63:0] i_fuse,
   input wire logic [7:0] i_core_avail,
   input wire logic [63:0] i_strand_running,
   output logic o_rvalid,
   output logic [63:0] o_rdata,
   output logic [63:0] o_run_ctl,
   output logic [63:0] o_halt_now,
   output logic o_io_valid,
   output spk_pkg::spk_tgt_e o_io_target,
   output logic [1:0] o_mem_sel
);
   logic set_we;
   logic clr_we;
   logic [63:0] run_vec;
   logic [63:0] serial_q;
   logic [63:0] fuse_q;
   logic [63:0] avail_q;
   logic [63:0] status_q;
   logic fuse_loaded_q;
   logic [63:0] rdata_d;

   initial begin
      if (STRANDS != spk_pkg::STRANDS) $error("spk_ncu_regs serves 64 strands only");
   end

   assign set_we = i_req && i_we && i_addr == spk_pkg::OFF_RUN_SET;
   assign clr_we = i_req && i_we && i_addr == spk_pkg::OFF_RUN_CLEAR;

   spk_park_vec #(.STRANDS(STRANDS)) u_park (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_set_we(set_we),
      .i_clr_we(clr_we),
      .i_data(i_wdata),
      .i_requester(i_requester),
      .o_run(run_vec)
   );

   spk_addr_decode u_dec (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(i_req),
      .i_addr(i_addr),
      .o_valid(o_io_valid),
      .o_target(o_io_target),
      .o_mem_sel(o_mem_sel)
   );

   // Fuse-fed values captured once after reset release; never written by software
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fuse_loaded_q <= 1'b0;
         serial_q <= '0;
         fuse_q <= spk_pkg::RST_FUSE;
         avail_q <= spk_pkg::RST_AVAIL;
      end else if (!fuse_loaded_q) begin
         fuse_loaded_q <= 1'b1;
         serial_q <= i_serial;
         fuse_q <= i_fuse;
         for (int c = 0; c < 8; c++) begin
            avail_q[c*8 +: 8] <= {8{i_core_avail[c]}};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         status_q <= '0;
      end else begin
         status_q <= i_strand_running;
      end
   end

   // Run control drives strands; a self-park pulses o_halt_now for the requester one cycle before o_run_ctl clears it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_run_ctl <= spk_pkg::RST_RUN;
         o_halt_now <= '0;
      end else begin
         o_run_ctl <= run_vec;
         o_halt_now <= '0;
         if (clr_we && i_wdata[i_requester] && (run_vec & ~i_wdata) != '0) begin
            o_halt_now[i_requester] <= 1'b1;
         end
      end
   end

   always_comb begin
      rdata_d = '0;
      case (i_addr)
         spk_pkg::OFF_IRQ_IDENT: rdata_d[5:0] = i_requester;
         spk_pkg::OFF_STRAND_IDENT: begin
            rdata_d[spk_pkg::STRAND_HI_LSB +: 6] = spk_pkg::STRANDS_PER_CORE_M1;
            rdata_d[spk_pkg::VPROC_HI_LSB +: 6] = spk_pkg::VPROC_M1;
            rdata_d[5:0] = i_requester;
         end
         spk_pkg::OFF_RUN_RW: rdata_d = run_vec;
         spk_pkg::OFF_RUN_STATUS: rdata_d = status_q;
         spk_pkg::OFF_SERIAL: rdata_d = serial_q;
         spk_pkg::OFF_FUSE: rdata_d = fuse_q;
         spk_pkg::OFF_AVAIL: rdata_d = avail_q;
         default: rdata_d = '0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
      end else begin
         o_rvalid <= i_req && !i_we;
         o_rdata <= (i_req && !i_we) ? rdata_d : '0;
      end
   end
endmodule : spk_ncu_regs
`default_nettype wire

/* sim/spk_ncu_props.sv */
// Checker of run control, identity reads and decode
`default_nettype none
module spk_ncu_props (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [39:0] i_addr,
   input wire logic [63:0] i_wdata,
   input wire logic [5:0] i_requester,
   input wire logic o_rvalid,
   input wire logic [63:0] o_rdata,
   input wire logic [63:0] o_run_ctl,
   input wire spk_pkg::spk_tgt_e o_io_target,
   input wire logic [1:0] o_mem_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] sel_w;
   logic [7:0] code_w;
   assign sel_w = i_addr[13:12];
   assign code_w = i_addr[39:32];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence wr_s(logic [39:0] a); i_req && i_we && i_addr == a; endsequence
   sequence rd_s(logic [39:0] a); i_req && !i_we && i_addr == a; endsequence
   read_answer_a: assert property (i_req && !i_we |=> o_rvalid)
      else $error("read not answered");
   set_bits_a: assert property (wr_s(spk_pkg::OFF_RUN_SET) |=> ##1
      (o_run_ctl & $past(i_wdata, 2)) == $past(i_wdata, 2)) else $error("set lost");
   clear_bits_a: assert property (wr_s(spk_pkg::OFF_RUN_CLEAR) |=> ##1
      (o_run_ctl & $past(i_wdata, 2) & ~(64'h1 << $past(i_requester, 2))) == '0)
      else $error("clear lost");
   one_runs_a: assert property (o_run_ctl != '0) else $error("all parked");
   irq_ident_a: assert property (rd_s(spk_pkg::OFF_IRQ_IDENT) |=>
      o_rdata == {58'h0, $past(i_requester)}) else $error("irq id");
   strand_ident_a: assert property (rd_s(spk_pkg::OFF_STRAND_IDENT) |=>
      o_rdata == {26'h0, 6'h07, 10'h0, 6'h3F, 10'h0, $past(i_requester)}) else $error("id");
   mem_route_a: assert property (i_req && code_w == spk_pkg::CODE_MEM |=>
      o_io_target == spk_pkg::SPK_TGT_MEM && o_mem_sel == $past(sel_w)) else $error("mem");
   shared_route_a: assert property (i_req && code_w == spk_pkg::CODE_SHARED |=>
      o_io_target == spk_pkg::SPK_TGT_SHARED) else $error("shared");
endmodule : spk_ncu_props
bind spk_ncu_regs spk_ncu_props u_props (.i_clk, .i_rst, .i_req, .i_we, .i_addr, .i_wdata,
   .i_requester, .o_rvalid, .o_rdata, .o_run_ctl, .o_io_target, .o_mem_sel);
`default_nettype wire

/* sim/spk_strands.sv */
// Strand model: running status follows run control after a lag
`default_nettype none
module spk_strands (
   input wire logic i_clk,
   input wire logic [63:0] i_run,
   input wire logic [3:0] i_lag,
   output logic [63:0] o_running
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q = '0;
   initial o_running = '0;
   always @(posedge i_clk) begin
      if (o_running === i_run) begin
         wait_q <= '0;
      end else if (wait_q >= i_lag) begin
         o_running <= i_run;
         wait_q <= '0;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : spk_strands
`default_nettype wire

/* sim/strand_park_ctl_and_io_decode_bench.sv */
// Self-checking bench of strand-park registers and I/O decode
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module strand_park_ctl_and_io_decode_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_rst = 1, i_req = 0, i_we = 0, o_rvalid, o_io_valid;
   logic [39:0] i_addr = '0;
   logic [63:0] i_wdata = '0, i_serial, i_fuse, run_m, rd_v, halt_v, d, av;
   logic [63:0] o_rdata, o_run_ctl, o_halt_now, running;
   logic [7:0] i_core_avail;
   logic [5:0] i_requester = '0, rq = '0;
   logic [3:0] lag = '0;
   logic [1:0] o_mem_sel;
   spk_pkg::spk_tgt_e o_io_target, tg_v;
   logic [7:0] cd[4] = '{8'h80, 8'h83, 8'h89, 8'hFF};
   spk_pkg::spk_tgt_e ct[4] = '{spk_pkg::SPK_TGT_OWN, spk_pkg::SPK_TGT_CLK,
      spk_pkg::SPK_TGT_RESET, spk_pkg::SPK_TGT_BOOT};
   logic rv_v, iv_v;
   int fail_count = 0, n_tests = 0, cyc = 0;
   always #25 i_clk = ~i_clk;
   spk_ncu_regs DUT (.i_clk, .i_rst, .i_req, .i_we, .i_addr, .i_wdata, .i_requester,
      .i_serial, .i_fuse, .i_core_avail, .i_strand_running(running), .o_rvalid, .o_rdata,
      .o_run_ctl, .o_halt_now, .o_io_valid, .o_io_target, .o_mem_sel);
   spk_strands u_far (.i_clk, .i_run(o_run_ctl), .i_lag(lag), .o_running(running));
   task automatic end_sim;
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   task automatic acc(input logic we, input logic [39:0] a, input logic [63:0] w);
      @(posedge i_clk);
      i_req <= 1'b1;
      i_we <= we;
      i_addr <= a;
      i_wdata <= w;
      i_requester <= rq;
      @(posedge i_clk);
      i_req <= 1'b0;
      #1 rd_v = o_rdata;
      rv_v = o_rvalid;
      iv_v = o_io_valid;
      halt_v = o_halt_now;
      tg_v = o_io_target;
   endtask : acc
   task automatic rd(input logic [39:0] a, input logic [63:0] e, input string n);
      acc(1'b0, a, 64'h0);
      `CHK("rvalid", 1'b1, rv_v)
      `CHK(n, e, rd_v)
   endtask : rd
   task automatic sync;
      for (int k = 0; k < 60 && running !== run_m; k++) @(posedge i_clk) #1;
      `CHK("status", run_m, running)
      `CHK("run ctl", run_m, o_run_ctl)
      rd(spk_pkg::OFF_RUN_RW, run_m, "run");
   endtask : sync
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      void'($urandom(32'he4fc6833));
      i_serial = {$urandom, $urandom};
      i_fuse = {$urandom, $urandom};
      i_core_avail = 8'($urandom);
      for (int i = 0; i < 64; i++) av[i] = i_core_avail[i / 8];
      run_m = 64'h1;
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      sync;
      rd(spk_pkg::OFF_SERIAL, i_serial, "serial");
      acc(1'b1, spk_pkg::OFF_FUSE, 64'h0);
      rd(spk_pkg::OFF_FUSE, i_fuse, "fuse");
      rd(spk_pkg::OFF_AVAIL, av, "avail");
      for (int i = 0; i < 12; i++) begin
         rq = 6'($urandom);
         lag = 4'($urandom);
         rd(spk_pkg::OFF_IRQ_IDENT, {58'h0, rq}, "irq id");
         d = {$urandom, $urandom};
         if (i[0]) begin
            d = (i == 11) ? (64'h1 << rq) & running : d & running;
            acc(1'b1, spk_pkg::OFF_RUN_CLEAR, d);
            run_m = run_m & ~d;
            if (run_m == '0) run_m = 64'h1 << rq;
            if (i == 11) `CHK("halt", ((run_m & d) != '0) ? 64'h0 : d, halt_v)
         end else begin
            d = (i == 10) ? ~running : d & ~running;
            acc(1'b1, spk_pkg::OFF_RUN_SET, d);
            run_m = run_m | d;
         end
         sync;
      end
      acc(1'b1, spk_pkg::OFF_RUN_CLEAR, running);
      run_m = 64'h1 << rq;
      sync;
      foreach (cd[i]) begin
         acc(1'b0, {cd[i], 32'h0000_3000}, 64'h0);
         `CHK("io valid", 1'b1, iv_v)
         `CHK("route", ct[i], tg_v)
      end
      acc(1'b0, 40'h84_0000_2000, 64'h0);
      `CHK("mem sel", 2'b10, o_mem_sel)
      acc(1'b0, 40'hC7_0000_0000, 64'h0);
      `CHK("pcie", spk_pkg::SPK_TGT_PCIE, tg_v)
      acc(1'b0, 40'h90_0104_0058, 64'h0);
      `CHK("shared", spk_pkg::SPK_TGT_SHARED, tg_v)
      end_sim;
   end
endmodule : strand_park_ctl_and_io_decode_bench
`default_nettype wire
